// [design/modbus_cmd_scheduler.v]
// Function
// - Selector 0 disables; 1,2 continuous port1/2
// - Selectors 5,6 conditional on port 1/2
// - Selectors 9,10 one-shot control on port 1/2
// - Continuous commands issue on every list pass
// - Conditional compares outgoing block with retained copy
// - Any difference sends the whole data block
// - Conditional applies to write codes 5,6,15,16
// - Control command issues only on trigger rise
// - One issue per rise; host re-arms by clearing
// - Request addressed to record's slave address
// - Codes 1-4 select the read transactions
// - Codes 5,6,15,16 select the write transactions
// - Read source is slave start location
// - Write source is module memory start location
// - Count gives words, or bits for codes 1,2,15; codes 5,6 move one word
// - Read destination is module memory start location
// - Write destination is slave start location
// - Shared list of 100 ten-word records
// - Code 3 type: swap words, swap words and bytes, or none
`timescale 1ns/1ps
`include "modbus_cmd_defines.vh"

module modbus_cmd_scheduler #(
    parameter NREC   = `CMD_RECORDS,
    parameter REC_W  = `CMD_REC_WORDS,
    parameter DWORDS = `DATA_WORDS,
    parameter DAW    = 12,
    parameter CAW    = 10,
    parameter RAW    = 7,
    parameter FDEPTH = `FIFO_DEPTH,
    parameter FPW    = 1
) (
    input  wire             clock_i,
    input  wire             sys_rst_i,
    input  wire             ce_i,
    input  wire             cmd_wr_en_i,
    input  wire [CAW-1:0]   cmd_wr_addr_i,
    input  wire [15:0]      cmd_wr_data_i,
    input  wire [NREC-1:0]  trigger_i,
    input  wire             data_wr_en_i,
    input  wire [DAW-1:0]   data_addr_i,
    input  wire [15:0]      data_wr_data_i,
    output wire             data_wr_ready_o,
    output reg  [15:0]      data_rd_data_o,
    output wire             tx_valid_o,
    input  wire             tx_ready_i,
    output wire [15:0]      tx_data_o,
    output wire             tx_last_o,
    output wire             tx_port_o,
    input  wire             rx_valid_i,
    input  wire             rx_port_i,
    input  wire [15:0]      rx_data_i,
    input  wire             rx_last_i,
    output wire             rx_ready_o,
    output reg  [RAW-1:0]   scan_index_o,
    output reg  [1:0]       port_busy_o,
    output reg              pass_done_o
);

    localparam ST_SCAN = 3'h0;
    localparam ST_CMP  = 3'h1;
    localparam ST_HDR  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_NEXT = 3'h4;

    // ----------------
    // Storage
    // ----------------
    reg [15:0] cmd_mem    [0:NREC*REC_W-1];
    reg [15:0] data_mem   [0:DWORDS-1];
    reg [15:0] shadow_mem [0:DWORDS-1];

    reg [2:0]      state;
    reg [1:0]      hdr_idx;
    reg [15:0]     word_idx;
    reg [NREC-1:0] trig_prev;
    reg [NREC-1:0] pending;
    reg            cur_port;
    reg            cur_write;
    reg [15:0]     cur_slave;
    reg [15:0]     cur_fc;
    reg [15:0]     cur_src;
    reg [15:0]     cur_dst;
    reg [15:0]     cur_cnt;
    reg [15:0]     cur_words;
    reg [15:0]     cur_type;
    reg            rx_rd   [0:1];
    reg [DAW-1:0]  rx_dst  [0:1];
    reg [15:0]     rx_cnt  [0:1];
    reg [15:0]     rx_idx  [0:1];
    reg [1:0]      rx_swap [0:1];

    // ----------------
    // Record decode
    // ----------------
    wire [CAW-1:0] rec_base = {{(CAW-RAW){1'b0}}, scan_index_o} * REC_W[CAW-1:0];
    wire [15:0] f_mode  = cmd_mem[rec_base + `REC_MODE];
    wire [15:0] f_slave = cmd_mem[rec_base + `REC_SLAVE];
    wire [15:0] f_fc    = cmd_mem[rec_base + `REC_FUNC];
    wire [15:0] f_src   = cmd_mem[rec_base + `REC_SRC];
    wire [15:0] f_cnt   = cmd_mem[rec_base + `REC_COUNT];
    wire [15:0] f_dst   = cmd_mem[rec_base + `REC_DST];
    wire [15:0] f_type  = cmd_mem[rec_base + `REC_TYPE];

    wire m_p1   = (f_mode == `MODE_CONT_P1) | (f_mode == `MODE_COND_P1)
                | (f_mode == `MODE_CTRL_P1);
    wire m_p2   = (f_mode == `MODE_CONT_P2) | (f_mode == `MODE_COND_P2)
                | (f_mode == `MODE_CTRL_P2);
    wire m_cond = (f_mode == `MODE_COND_P1) | (f_mode == `MODE_COND_P2);
    wire m_ctrl = (f_mode == `MODE_CTRL_P1) | (f_mode == `MODE_CTRL_P2);
    wire fc_rd  = (f_fc == `FC_RD_COIL) | (f_fc == `FC_RD_INP)
                | (f_fc == `FC_RD_HREG) | (f_fc == `FC_RD_IREG);
    wire fc_wr  = (f_fc == `FC_WR_COIL) | (f_fc == `FC_WR_REG)
                | (f_fc == `FC_WR_MCOIL) | (f_fc == `FC_WR_MREG);
    wire fc_bit = (f_fc == `FC_RD_COIL) | (f_fc == `FC_RD_INP) | (f_fc == `FC_WR_MCOIL);

    // Bit counts are packed sixteen to a memory word.
    wire [16:0] bit_words = ({1'b0, f_cnt} + 17'h0000f) >> 4;
    wire [15:0] f_words   = ((f_fc == `FC_WR_COIL) | (f_fc == `FC_WR_REG)) ? 16'h0001 :
                            fc_bit ? bit_words[15:0] : f_cnt;

    wire [NREC-1:0] trig_rise = trigger_i & ~trig_prev;

    // ----------------
    // Outgoing buffer
    // ----------------
    reg [17:0]    fifo_q [0:FDEPTH-1];
    reg [FPW-1:0] fifo_wp;
    reg [FPW-1:0] fifo_rp;
    reg [FPW:0]   fifo_cnt;

    wire fifo_full = (fifo_cnt == FDEPTH[FPW:0]);
    wire [DAW-1:0] out_addr = cur_src[DAW-1:0] + word_idx[DAW-1:0];
    wire [15:0]    out_word = data_mem[out_addr];
    wire data_more = cur_write && (cur_words != 16'h0000);

    reg        push;
    reg [17:0] push_word;
    always @* begin
        push      = 1'b0;
        push_word = 18'h00000;
        if (state == ST_HDR) begin
            push = ~fifo_full;
            case (hdr_idx)
                2'h0: push_word[15:0] = cur_slave;
                2'h1: push_word[15:0] = cur_fc;
                2'h2: push_word[15:0] = cur_write ? cur_dst : cur_src;
                default: push_word[15:0] = cur_cnt;
            endcase
            push_word[16] = (hdr_idx == `HDR_LAST) && !data_more;
            push_word[17] = cur_port;
        end else if (state == ST_DATA) begin
            push      = ~fifo_full;
            push_word = {cur_port, word_idx == cur_words - 16'h0001, out_word};
        end
    end

    wire pop = ce_i && tx_valid_o && tx_ready_i;
    wire do_push = ce_i && push;
    assign tx_valid_o = (fifo_cnt != {(FPW+1){1'b0}});
    assign tx_data_o  = fifo_q[fifo_rp][15:0];
    assign tx_last_o  = fifo_q[fifo_rp][16];
    assign tx_port_o  = fifo_q[fifo_rp][17];

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_wp  <= {FPW{1'b0}};
            fifo_rp  <= {FPW{1'b0}};
            fifo_cnt <= {(FPW+1){1'b0}};
        end else if (ce_i) begin
            if (do_push) begin
                fifo_wp <= fifo_wp + 1'b1;
            end
            if (pop) begin
                fifo_rp <= fifo_rp + 1'b1;
            end
            if (do_push && !pop) begin
                fifo_cnt <= fifo_cnt + 1'b1;
            end else if (pop && !do_push) begin
                fifo_cnt <= fifo_cnt - 1'b1;
            end
        end
    end

    // ----------------
    // Return path
    // ----------------
    wire          rp      = rx_port_i;
    wire          rx_take = ce_i && rx_valid_i;
    wire          rx_keep = rx_take && rx_rd[rp] && (rx_idx[rp] < rx_cnt[rp]);
    wire          unpaired = !rx_idx[rp][0] && (rx_idx[rp] + 16'h0001 == rx_cnt[rp]);
    wire [15:0]   rx_pos  = (rx_swap[rp] != 2'h0 && !unpaired) ?
                            (rx_idx[rp] ^ 16'h0001) : rx_idx[rp];
    wire [15:0]   rx_word = (rx_swap[rp] == 2'h2) ?
                            {rx_data_i[7:0], rx_data_i[15:8]} : rx_data_i;
    wire [DAW-1:0] rx_addr = rx_dst[rp] + rx_pos[DAW-1:0];
    assign rx_ready_o      = 1'b1;
    // Returned data takes the memory port first; a host write waits while reply words are stored.
    assign data_wr_ready_o = ~rx_keep;

    always @(posedge clock_i) begin
        if (ce_i) begin
            if (cmd_wr_en_i) begin
                cmd_mem[cmd_wr_addr_i] <= cmd_wr_data_i;
            end
            if (rx_keep) begin
                data_mem[rx_addr] <= rx_word;
            end else if (data_wr_en_i) begin
                data_mem[data_addr_i] <= data_wr_data_i;
            end
            if (state == ST_DATA && do_push) begin
                shadow_mem[out_addr] <= out_word;
            end
            if (do_push) begin
                fifo_q[fifo_wp] <= push_word;
            end
            data_rd_data_o <= data_mem[data_addr_i];
        end
    end

    // ----------------
    // Scheduler
    // ----------------
    wire issue   = (state == ST_HDR) && (hdr_idx == 2'h0) && do_push;
    wire rx_done = rx_take && rx_last_i;
    wire [1:0] busy_set = issue ? (cur_port ? 2'h2 : 2'h1) : 2'h0;
    wire [1:0] busy_clr = rx_done ? (rp ? 2'h2 : 2'h1) : 2'h0;
    wire f_port = m_p2;
    wire [NREC-1:0] pend_clr = (state == ST_SCAN && m_ctrl && !port_busy_o[f_port])
                             ? ({{(NREC-1){1'b0}}, 1'b1} << scan_index_o) : {NREC{1'b0}};
    integer p;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state        <= ST_SCAN;
            hdr_idx      <= 2'h0;
            word_idx     <= 16'h0000;
            scan_index_o <= {RAW{1'b0}};
            port_busy_o  <= 2'h0;
            pass_done_o  <= 1'b0;
            trig_prev    <= {NREC{1'b0}};
            pending      <= {NREC{1'b0}};
            cur_port     <= 1'b0;
            cur_write    <= 1'b0;
            cur_slave    <= 16'h0000;
            cur_fc       <= 16'h0000;
            cur_src      <= 16'h0000;
            cur_dst      <= 16'h0000;
            cur_cnt      <= 16'h0000;
            cur_words    <= 16'h0000;
            cur_type     <= 16'h0000;
            for (p = 0; p < 2; p = p + 1) begin
                rx_rd[p]   <= 1'b0;
                rx_dst[p]  <= {DAW{1'b0}};
                rx_cnt[p]  <= 16'h0000;
                rx_idx[p]  <= 16'h0000;
                rx_swap[p] <= 2'h0;
            end
        end else if (ce_i) begin
            pass_done_o <= 1'b0;
            trig_prev   <= trigger_i;
            // A rise in the cycle of its own clear is kept for the next pass.
            pending     <= (pending & ~pend_clr) | trig_rise;
            port_busy_o <= (port_busy_o & ~busy_clr) | busy_set;
            if (rx_take) begin
                rx_idx[rp] <= rx_last_i ? 16'h0000 : rx_idx[rp] + 16'h0001;
            end
            if (issue) begin
                rx_rd[cur_port]   <= ~cur_write;
                rx_dst[cur_port]  <= cur_dst[DAW-1:0];
                rx_cnt[cur_port]  <= cur_words;
                rx_idx[cur_port]  <= 16'h0000;
                rx_swap[cur_port] <= (cur_fc != `FC_RD_HREG) ? 2'h0 :
                                     (cur_type == `SWAP_WORD) ? 2'h1 :
                                     (cur_type == `SWAP_BOTH) ? 2'h2 : 2'h0;
            end
            case (state)
                ST_SCAN: begin
                    cur_port  <= f_port;
                    cur_write <= fc_wr;
                    cur_slave <= f_slave;
                    cur_fc    <= f_fc;
                    cur_src   <= f_src;
                    cur_dst   <= f_dst;
                    cur_cnt   <= f_cnt;
                    cur_words <= f_words;
                    cur_type  <= f_type;
                    word_idx  <= 16'h0000;
                    hdr_idx   <= 2'h0;
                    if (!(m_p1 || m_p2) || !(fc_rd || fc_wr)) begin
                        state <= ST_NEXT;
                    end else if (m_ctrl && !pending[scan_index_o]) begin
                        state <= ST_NEXT;
                    end else if (port_busy_o[f_port]) begin
                        state <= ST_SCAN;
                    end else if (m_cond && fc_wr) begin
                        state <= ST_CMP;
                    end else begin
                        state <= ST_HDR;
                    end
                end
                ST_CMP: begin
                    if (word_idx == cur_words) begin
                        state <= ST_NEXT;
                    end else if (out_word != shadow_mem[out_addr]) begin
                        word_idx <= 16'h0000;
                        state    <= ST_HDR;
                    end else begin
                        word_idx <= word_idx + 16'h0001;
                    end
                end
                ST_HDR: begin
                    if (do_push) begin
                        hdr_idx <= hdr_idx + 2'h1;
                        if (hdr_idx == `HDR_LAST) begin
                            state <= data_more ? ST_DATA : ST_NEXT;
                        end
                    end
                end
                ST_DATA: begin
                    if (do_push) begin
                        word_idx <= word_idx + 16'h0001;
                        if (word_idx == cur_words - 16'h0001) begin
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    state <= ST_SCAN;
                    if (scan_index_o == NREC[RAW-1:0] - 1'b1) begin
                        scan_index_o <= {RAW{1'b0}};
                        pass_done_o  <= 1'b1;
                    end else begin
                        scan_index_o <= scan_index_o + 1'b1;
                    end
                end
                default: begin
                    state <= ST_SCAN;
                end
            endcase
        end
    end

endmodule // modbus_cmd_scheduler

// [design/modbus_cmd_defines.vh]
`ifndef MODBUS_CMD_DEFINES_VH
`define MODBUS_CMD_DEFINES_VH

// ----------------
// List and memory sizes
// ----------------
`define CMD_RECORDS   100
`define CMD_REC_WORDS 10
`define DATA_WORDS    4000
`define FIFO_DEPTH    2

// ----------------
// Word offsets inside one command record
// ----------------
`define REC_MODE  10'h000
`define REC_SLAVE 10'h001
`define REC_FUNC  10'h002
`define REC_SRC   10'h003
`define REC_COUNT 10'h004
`define REC_DST   10'h005
`define REC_TYPE  10'h006

// ----------------
// Port/mode selector values
// ----------------
`define MODE_OFF     16'h0000
`define MODE_CONT_P1 16'h0001
`define MODE_CONT_P2 16'h0002
`define MODE_COND_P1 16'h0005
`define MODE_COND_P2 16'h0006
`define MODE_CTRL_P1 16'h0009
`define MODE_CTRL_P2 16'h000a

// ----------------
// Function codes
// ----------------
`define FC_RD_COIL  16'h0001
`define FC_RD_INP   16'h0002
`define FC_RD_HREG  16'h0003
`define FC_RD_IREG  16'h0004
`define FC_WR_COIL  16'h0005
`define FC_WR_REG   16'h0006
`define FC_WR_MCOIL 16'h000f
`define FC_WR_MREG  16'h0010

// ----------------
// Receive swap types and request header length
// ----------------
`define SWAP_NONE  16'h0000
`define SWAP_WORD  16'h0001
`define SWAP_BOTH  16'h0002
`define HDR_LAST   2'h3

`endif

// [tb/modbus_cmd_scheduler_checker.sv]
`timescale 1ns/1ps
module modbus_cmd_checker #(
    parameter NREC = 100,
    parameter RAW  = 7
) (
    input  wire            clock_i,
    input  wire            sys_rst_i,
    input  wire            ce_i,
    input  wire            data_wr_ready_o,
    input  wire            tx_valid_o,
    input  wire            tx_ready_i,
    input  wire [15:0]     tx_data_o,
    input  wire            tx_last_o,
    input  wire            tx_port_o,
    input  wire            rx_valid_i,
    input  wire            rx_port_i,
    input  wire            rx_last_i,
    input  wire            rx_ready_o,
    input  wire [RAW-1:0]  scan_index_o,
    input  wire [1:0]      port_busy_o,
    input  wire            pass_done_o
);
    // ------------------------------------------------------------------
    // Ports that have sent a full request and still wait for the reply.
    // ------------------------------------------------------------------
    reg [1:0] waiting;
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            waiting <= 2'h0;
        end else if (ce_i) begin
            if (tx_valid_o && tx_ready_i && tx_last_o) waiting[tx_port_o] <= 1'b1;
            if (rx_valid_i && rx_last_i) waiting[rx_port_i] <= 1'b0;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_tx_hold_stall: assert property (tx_valid_o && !(tx_ready_i && ce_i) |=> tx_valid_o
        && $stable(tx_data_o) && $stable(tx_last_o) && $stable(tx_port_o))
        else $error("request word changed while stalled");
    a_rx_always_ready: assert property (rx_ready_o) else $error("reply input refused");
    a_scan_in_order: assert property ($changed(scan_index_o) |->
        scan_index_o == $past(scan_index_o) + 1'b1
        || (scan_index_o == 0 && $past(scan_index_o) == NREC - 1))
        else $error("record visit out of order");
    a_pass_one_pulse: assert property (pass_done_o |=> !pass_done_o)
        else $error("pass pulse too long");
    a_ce_freeze: assert property (!ce_i |=> $stable(scan_index_o)
        && $stable(port_busy_o) && $stable(tx_valid_o)) else $error("state moved with ce low");
    a_busy_until_last: assert property (port_busy_o[0]
        && !(ce_i && rx_valid_i && rx_last_i && !rx_port_i) |=> port_busy_o[0])
        else $error("port busy dropped without reply end");
    a_one_outstanding: assert property (tx_valid_o |-> !waiting[tx_port_o])
        else $error("second request before reply");
    a_store_blocks_host: assert property (!data_wr_ready_o |-> rx_valid_i)
        else $error("host write refused with no reply word");
endmodule // modbus_cmd_checker

bind modbus_cmd_scheduler modbus_cmd_checker #(.NREC(NREC), .RAW(RAW)) u_checker (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .data_wr_ready_o(data_wr_ready_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o), .tx_port_o(tx_port_o), .rx_valid_i(rx_valid_i),
    .rx_port_i(rx_port_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
    .scan_index_o(scan_index_o), .port_busy_o(port_busy_o), .pass_done_o(pass_done_o));

// [tb/modbus_slave_model.sv]
`timescale 1ns/1ps
module modbus_slave_model (
    input  wire        clock_i,
    input  wire        ce_i,
    input  wire        slow_i,
    input  wire        tx_valid_i,
    input  wire [15:0] tx_data_i,
    input  wire        tx_last_i,
    input  wire        tx_port_i,
    output reg         tx_ready_o,
    output reg         rx_valid_o,
    output reg         rx_port_o,
    output reg  [15:0] rx_data_o,
    output reg         rx_last_o
);
    // ------------------------------------------------------------------
    // Slave station: takes a request, then answers on the same port.
    // ------------------------------------------------------------------
    reg [15:0] req [0:31];
    integer    req_len;
    integer    req_cnt;
    reg        req_port;
    integer    n;
    integer    i;
    task reply;
        integer cnt;
        begin
            tx_ready_o <= 1'b0;
            req_len = n;
            req_port = tx_port_i;
            req_cnt = req_cnt + 1;
            n = 0;
            cnt = 1;
            if (req[1] == 16'h0003 || req[1] == 16'h0004) cnt = req[3];
            if (req[1] == 16'h0001 || req[1] == 16'h0002) cnt = (req[3] + 15) / 16;
            repeat (slow_i ? 6 : 1) @(posedge clock_i);
            for (i = 0; i < cnt; i = i + 1) begin
                rx_valid_o <= 1'b1;
                rx_port_o <= req_port;
                rx_data_o <= {req[0][7:0], req[2][7:0] + i[7:0]};
                rx_last_o <= (i == cnt - 1);
                @(posedge clock_i);
                while (!ce_i) @(posedge clock_i);
            end
            rx_valid_o <= 1'b0;
            rx_last_o <= 1'b0;
            // A released data line must not look like a held word.
            rx_data_o <= ~rx_data_o;
        end
    endtask
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_port_o = 1'b0;
        rx_data_o = 16'h0000;
        rx_last_o = 1'b0;
        req_cnt = 0;
        req_len = 0;
        n = 0;
        forever begin
            @(posedge clock_i);
            if (tx_valid_i && tx_ready_o && ce_i) begin
                if (n < 32) req[n] = tx_data_i;
                n = n + 1;
                if (tx_last_i) reply;
            end
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
        end
    end
endmodule // modbus_slave_model

// [tb/test_modbus_cmd_scheduler.sv]
`timescale 1ns/1ps
module test_modbus_cmd_scheduler;
    reg          clock_i, sys_rst_i, ce_i, cmd_wr_en_i, data_wr_en_i, slow_i;
    reg  [9:0]   cmd_wr_addr_i;
    reg  [15:0]  cmd_wr_data_i, data_wr_data_i, f, e, got;
    reg  [99:0]  trigger_i;
    reg  [11:0]  data_addr_i;
    wire         data_wr_ready_o, tx_valid_o, tx_ready_i, tx_last_o, tx_port_o, pass_done_o;
    wire [15:0]  data_rd_data_o, tx_data_o, rx_data_i;
    wire         rx_valid_i, rx_port_i, rx_last_i, rx_ready_o;
    wire [6:0]   scan_index_o;
    wire [1:0]   port_busy_o;
    integer      fail_count, cmp_count, i, k, seen, nw;
    modbus_cmd_scheduler u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .cmd_wr_en_i(cmd_wr_en_i), .cmd_wr_addr_i(cmd_wr_addr_i), .cmd_wr_data_i(cmd_wr_data_i),
        .trigger_i(trigger_i), .data_wr_en_i(data_wr_en_i), .data_addr_i(data_addr_i),
        .data_wr_data_i(data_wr_data_i), .data_wr_ready_o(data_wr_ready_o),
        .data_rd_data_o(data_rd_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_port_o(tx_port_o),
        .rx_valid_i(rx_valid_i), .rx_port_i(rx_port_i), .rx_data_i(rx_data_i),
        .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .scan_index_o(scan_index_o),
        .port_busy_o(port_busy_o), .pass_done_o(pass_done_o));
    modbus_slave_model u_slave (.clock_i(clock_i), .ce_i(ce_i), .slow_i(slow_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
        .tx_port_i(tx_port_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
        .rx_port_o(rx_port_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i));
    // ------------------------------------------------------------------
    // Access tasks and comparisons.
    // ------------------------------------------------------------------
    task check(input [15:0] g, input [15:0] x);
        begin
            cmp_count = cmp_count + 1;
            if (g !== x) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, x);
            end
        end
    endtask
    task test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task idle;
        begin
            cmd_wr_en_i <= 1'b0;
            data_wr_en_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task cmd_wr(input integer a, input [15:0] v);
        begin
            cmd_wr_en_i <= 1'b1;
            cmd_wr_addr_i <= a[9:0];
            cmd_wr_data_i <= v;
            @(posedge clock_i);
        end
    endtask
    // Mode goes last so the scheduler never runs a half-written record.
    task set_rec(input integer r, input [15:0] m, s, fc, a, c, d, t);
        begin
            cmd_wr(r * 10 + 1, s);
            cmd_wr(r * 10 + 2, fc);
            cmd_wr(r * 10 + 3, a);
            cmd_wr(r * 10 + 4, c);
            cmd_wr(r * 10 + 5, d);
            cmd_wr(r * 10 + 6, t);
            cmd_wr(r * 10, m);
            idle;
        end
    endtask
    task data_wr(input [11:0] a, input [15:0] v);
        reg r;
        begin
            r = 1'b0;
            data_wr_en_i <= 1'b1;
            data_addr_i <= a;
            data_wr_data_i <= v;
            while (!r) begin
                @(negedge clock_i);
                r = (data_wr_ready_o === 1'b1);
                @(posedge clock_i);
            end
        end
    endtask
    task data_rd(input [11:0] a);
        begin
            data_addr_i <= a;
            @(posedge clock_i);
            @(negedge clock_i);
            got = data_rd_data_o;
            @(posedge clock_i);
        end
    endtask
    task wait_req(input integer old);
        integer w;
        begin
            for (w = 0; w < 3000 && u_slave.req_cnt == old; w = w + 1) @(posedge clock_i);
            check({15'h0000, u_slave.req_cnt == old}, 16'h0000);
        end
    endtask
    task wait_pass(input integer p);
        integer w;
        begin
            repeat (p) begin
                @(negedge clock_i);
                for (w = 0; w < 5000 && pass_done_o !== 1'b1; w = w + 1) @(negedge clock_i);
            end
            @(posedge clock_i);
        end
    endtask
    task chk_hdr(input [15:0] s, fc, a, c, len, p);
        begin
            check(u_slave.req[0], s);
            check(u_slave.req[1], fc);
            check(u_slave.req[2], a);
            check(u_slave.req[3], c);
            check(u_slave.req_len[15:0], len);
            check({15'h0000, u_slave.req_port}, p);
        end
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #300000;
        fail_count = fail_count + 1;
        $display("unexpected at %0t: run did not finish", $time);
        test_done;
    end
    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        cmp_count = 0;
        {ce_i, cmd_wr_en_i, data_wr_en_i, slow_i, trigger_i} = 0;
        {cmd_wr_addr_i, cmd_wr_data_i, data_addr_i, data_wr_data_i} = 0;
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        repeat (5) @(posedge clock_i);
        // The list is loaded under reset so no unknown record is ever scanned.
        for (i = 0; i < 1000; i = i + 1) cmd_wr(i, 16'h0000);
        idle;
        sys_rst_i <= 1'b0;
        for (i = 0; i < 32; i = i + 1) data_wr(12'h200 + i, 16'h1000 + i);
        data_wr(12'h205, 16'h7700);
        idle;
        for (k = 0; k < 6; k = k + 1) begin
            f = (k < 3) ? 16'h0003 : (k == 3) ? 16'h0004 : k - 3;
            seen = u_slave.req_cnt;
            set_rec(99, (k == 1) ? 2 : 1, 17, f, 16'h0020, 4, 16'h0100 + 8 * k, (k < 3) ? k : 0);
            wait_req(seen);
            chk_hdr(17, f, 16'h0020, 4, 4, k == 1);
            wait_req(seen + 1);
            set_rec(99, 0, 17, f, 16'h0020, 4, 16'h0100 + 8 * k, 0);
            wait_pass(2);
            for (i = 0; i < 4 && k < 4; i = i + 1) begin
                e = 16'h1120 + (((k == 1) || (k == 2)) ? (i ^ 1) : i);
                if (k == 2) e = {e[7:0], e[15:8]};
                data_rd(16'h0100 + 8 * k + i);
                check(got, e);
            end
        end
        $display("read commands done");
        slow_i <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            f = (k < 2) ? 5 + k : 13 + k;
            nw = (k < 2) ? 1 : (k == 2) ? 2 : 20;
            seen = u_slave.req_cnt;
            set_rec(0, 1, 3, f, 16'h0200, 20, 16'h0300, 0);
            wait_req(seen);
            chk_hdr(3, f, 16'h0300, 20, 4 + nw, 0);
            for (i = 0; i < nw; i = i + 1)
                check(u_slave.req[4 + i], (i == 5) ? 16'h7700 : 16'h1000 + i);
            set_rec(0, 0, 3, f, 16'h0200, 20, 16'h0300, 0);
            wait_pass(2);
        end
        slow_i <= 1'b0;
        $display("write commands done");
        for (k = 0; k < 2; k = k + 1) begin
            seen = u_slave.req_cnt;
            set_rec(0, 5 + k, 9, 16, 16'h0204, 4, 16'h0040, 0);
            data_wr(12'h205, 16'h7710 + k);
            idle;
            wait_req(seen);
            chk_hdr(9, 16, 16'h0040, 4, 8, k);
            check(u_slave.req[4], 16'h1004);
            check(u_slave.req[5], 16'h7710 + k);
            wait_pass(3);
            check(u_slave.req_cnt - seen, 1);
        end
        set_rec(0, 0, 9, 16, 16'h0204, 4, 16'h0040, 0);
        $display("conditional commands done");
        for (k = 0; k < 2; k = k + 1) begin
            seen = u_slave.req_cnt;
            set_rec(5, 9 + k, 4, 6, 16'h0200, 1, 16'h0010, 0);
            wait_pass(2);
            trigger_i[5] <= 1'b1;
            wait_req(seen);
            chk_hdr(4, 6, 16'h0010, 1, 5, k);
            wait_pass(3);
            trigger_i[5] <= 1'b0;
            wait_pass(2);
            check(u_slave.req_cnt - seen, 1);
        end
        ce_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        ce_i <= 1'b1;
        $display("control commands done");
        test_done;
    end
endmodule // test_modbus_cmd_scheduler
